// file: clkctl_pkg.sv
package clkctl_pkg;
	localparam int CORE_CLOCK_MHZ = 200;
	localparam int RATIO_W = 2;
	localparam int IRQ_W = 4;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CORE_PERIOD_PS = 1000000 / CORE_CLOCK_MHZ;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] RATIO_1_4 = 2'h0;
	localparam logic [1:0] RATIO_1_2P5 = 2'h1;
	localparam logic [1:0] RATIO_1_2 = 2'h2;
	localparam logic [1:0] RATIO_1_3 = 2'h3;
	// Interface-clock divider in half-core-cycles (ratio times two)
	localparam logic [3:0] HALF_DIV_1_4 = 4'h8;
	localparam logic [3:0] HALF_DIV_1_2P5 = 4'h5;
	localparam logic [3:0] HALF_DIV_1_2 = 4'h4;
	localparam logic [3:0] HALF_DIV_1_3 = 4'h6;
	localparam logic ENDIAN_LITTLE = 1'h0;
	localparam logic ENDIAN_BIG = 1'h1;
	localparam logic [1:0] RATIO_RST = 2'h2;
	localparam logic ENDIAN_RST = 1'h0;
	localparam logic [IRQ_W-1:0] IRQ_N_RST = 4'hf;
	typedef enum logic [1:0] {PM_RUN, PM_HALT, PM_DOZE} power_mode_t;
endpackage

// file: input_sampler.sv
`timescale 1ns/100ps
module input_sampler #(
	parameter int W = 4
) (
	input wire logic mclk, // Reference clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [W-1:0] pin_n, // Active-low pins
	output logic [W-1:0] req_q // Sampled request, active high
);
	typedef struct packed {
		logic [W-1:0] req;
	} smp_t;
	smp_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.req = ~pin_n;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign req_q = s_q.req;
endmodule

// file: clock_strap_and_interrupt_inputs.sv
// Functional notes
// - Core clock is 200 MHz at every ratio.
// - Ratio strap picks 1:4, 1:2.5, 1:2, 1:3.
// - Low-power status high in halt or doze.
// - Endian strap taken on first edge after reset release: 0 little, 1 big.
// - General interrupts sampled each reference edge.
// - Non-maskable interrupt sampled each reference edge.
`timescale 1ns/100ps
module clock_strap_and_interrupt_inputs
	import clkctl_pkg::*;
#(
	parameter int NIRQ = clkctl_pkg::IRQ_W
) (
	input wire logic mclk, // Reference clock input
	input wire logic rst_n, // Async reset, active low
	input wire logic [clkctl_pkg::RATIO_W-1:0] clock_ratio_select, // Strap
	input wire logic endian_strap, // Byte-order strap
	input wire logic halt_req, // Core enters halt
	input wire logic doze_req, // Core enters doze
	input wire logic wake, // Core leaves halt or doze
	input wire logic [NIRQ-1:0] irq_n, // General interrupts, active low
	input wire logic nmi_n, // Non-maskable interrupt, active low
	output logic [clkctl_pkg::RATIO_W-1:0] ratio_q, // Held ratio
	output logic [3:0] half_div_q, // Interface divider, half core cycles
	output logic [7:0] core_mhz_q, // Core clock frequency
	output logic big_endian_q, // Held byte order
	output logic low_power_status, // High in halt or doze
	output logic [NIRQ-1:0] irq_q, // Sampled interrupts, active high
	output logic nmi_q // Sampled NMI, active high
);
	import clkctl_pkg::*;

	default clocking cyc @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	typedef struct packed {
		logic armed;
		logic [RATIO_W-1:0] ratio;
		logic [3:0] half_div;
		logic endian;
		power_mode_t mode;
		logic lp;
		logic [7:0] mhz;
	} st_t;
	st_t s_q, s_d;

	function automatic logic [3:0] half_div_of(input logic [1:0] r);
		unique case (r)
			RATIO_1_4: half_div_of = HALF_DIV_1_4;
			RATIO_1_2P5: half_div_of = HALF_DIV_1_2P5;
			RATIO_1_2: half_div_of = HALF_DIV_1_2;
			RATIO_1_3: half_div_of = HALF_DIV_1_3;
		endcase
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.mhz = 8'(CORE_CLOCK_MHZ);
		// Async reset can only load constants, so the straps are
		// caught on the first edge after release and then held
		if (!s_q.armed) begin
			s_d.armed = 1'h1;
			s_d.ratio = clock_ratio_select;
			s_d.half_div = half_div_of(clock_ratio_select);
			s_d.endian = endian_strap;
		end
		unique case (s_q.mode)
			PM_RUN: begin
				if (halt_req) begin
					s_d.mode = PM_HALT;
				end else if (doze_req) begin
					s_d.mode = PM_DOZE;
				end
			end
			PM_HALT, PM_DOZE: begin
				if (wake) begin
					s_d.mode = PM_RUN;
				end
			end
			default: s_d.mode = PM_RUN;
		endcase
		s_d.lp = (s_d.mode != PM_RUN);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{armed: 1'h0, ratio: RATIO_RST,
				half_div: HALF_DIV_1_2, endian: ENDIAN_RST,
				mode: PM_RUN, lp: 1'h0, mhz: 8'(CORE_CLOCK_MHZ)};
		end else begin
			s_q <= s_d;
		end
	end

	input_sampler #(.W(NIRQ)) u_irq (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_n(irq_n),
		.req_q(irq_q)
	);

	input_sampler #(.W(1)) u_nmi (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_n(nmi_n),
		.req_q(nmi_q)
	);

	assign ratio_q = s_q.ratio;
	assign half_div_q = s_q.half_div;
	assign big_endian_q = s_q.endian;
	assign low_power_status = s_q.lp;
	assign core_mhz_q = s_q.mhz;

	sequence strap_capture;
		!s_q.armed;
	endsequence

	sequence halt_enter;
		!low_power_status && halt_req;
	endsequence

	sequence doze_enter;
		!low_power_status && !halt_req && doze_req;
	endsequence

	sequence run_idle;
		!low_power_status && !halt_req && !doze_req;
	endsequence

	sequence lp_hold;
		low_power_status && !wake;
	endsequence

	sequence lp_leave;
		low_power_status && wake;
	endsequence

	sequence halt_then_wake;
		halt_enter ##1 wake;
	endsequence

	chk_strap_hold: assert property (
		s_q.armed
		|=> $stable(ratio_q) && $stable(big_endian_q))
		else $error("strap value changed after capture");

	chk_div_hold: assert property (
		s_q.armed
		|=> $stable(half_div_q))
		else $error("divider changed after capture");

	chk_strap_take: assert property (
		strap_capture
		|=> big_endian_q == $past(endian_strap))
		else $error("endian strap not captured");

	chk_ratio_take: assert property (
		strap_capture
		|=> ratio_q == $past(clock_ratio_select))
		else $error("ratio strap not captured");

	chk_arm_once: assert property (
		strap_capture
		|=> s_q.armed)
		else $error("strap capture not closed");

	chk_ratio_map: assert property (
		ratio_q == RATIO_1_4
		|-> half_div_q == HALF_DIV_1_4)
		else $error("divider wrong for ratio 1:4");

	chk_div_two_half: assert property (
		ratio_q == RATIO_1_2P5
		|-> half_div_q == HALF_DIV_1_2P5)
		else $error("divider wrong for ratio 1:2.5");

	chk_div_half: assert property (
		ratio_q == RATIO_1_2
		|-> half_div_q == HALF_DIV_1_2)
		else $error("divider wrong for ratio 1:2");

	chk_div_third: assert property (
		ratio_q == RATIO_1_3
		|-> half_div_q == HALF_DIV_1_3)
		else $error("divider wrong for ratio 1:3");

	chk_lp_status: assert property (
		lp_hold
		|=> low_power_status)
		else $error("low-power status dropped without wake");

	chk_lp_enter: assert property (
		halt_enter
		|=> low_power_status)
		else $error("halt not shown on status");

	chk_doze_enter: assert property (
		doze_enter
		|=> low_power_status)
		else $error("doze not shown on status");

	chk_lp_wake: assert property (
		lp_leave
		|=> !low_power_status)
		else $error("status still high after wake");

	chk_run_idle: assert property (
		run_idle
		|=> !low_power_status)
		else $error("status high without request");

	chk_halt_first: assert property (
		halt_enter
		|=> s_q.mode == PM_HALT)
		else $error("halt request did not win");

	chk_doze_mode: assert property (
		doze_enter
		|=> s_q.mode == PM_DOZE)
		else $error("doze request not taken");

	chk_halt_round: assert property (
		halt_then_wake
		|=> !low_power_status)
		else $error("halt then wake left status high");

	chk_irq_sample: assert property (
		##1
		irq_q == ~$past(irq_n))
		else $error("interrupt not sampled");

	chk_irq_idle: assert property (
		irq_n == {NIRQ{1'h1}}
		|=> irq_q == '0)
		else $error("idle interrupt pins seen as request");

	chk_nmi_sample: assert property (
		##1
		nmi_q == !$past(nmi_n))
		else $error("nmi not sampled");

	chk_nmi_idle: assert property (
		nmi_n
		|=> !nmi_q)
		else $error("idle nmi pin seen as request");

	chk_core_freq: assert property (
		1'h1
		|-> core_mhz_q == 8'(CORE_CLOCK_MHZ))
		else $error("core frequency wrong");
endmodule

// file: board_model.sv
`timescale 1ns/100ps
module board_model (
	input wire logic [3:0] irq_val_n, // Level the sources drive
	input wire logic irq_drv, // Interrupt sources driving
	input wire logic nmi_drv, // NMI source asserting
	output logic [3:0] irq_n, // Interrupt pins
	output logic nmi_n // NMI pin
);
	// Released lines float to the pull-up level
	assign irq_n = irq_drv ? irq_val_n : 4'hf;
	assign nmi_n = nmi_drv ? 1'h0 : 1'h1;
endmodule

// file: clock_strap_and_interrupt_inputs_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module clock_strap_and_interrupt_inputs_test;
	import clkctl_pkg::*;
	logic mclk = 1'h0, rst_n = 1'h0, endian_strap = 1'h0;
	logic halt_req = 1'h0, doze_req = 1'h0, wake = 1'h0;
	logic irq_drv = 1'h0, nmi_drv = 1'h0, nmi_n, big_endian_q, nmi_q;
	logic [1:0] sel = 2'h0, ratio_q;
	logic [3:0] irq_val_n = 4'hf, irq_n, half_div_q, irq_q;
	logic [7:0] core_mhz_q;
	logic low_power_status;
	logic [3:0] div_tab [4] = '{4'h8, 4'h5, 4'h4, 4'h6};
	int fail_count = 0, compares = 0;
	clock_strap_and_interrupt_inputs DUT (.mclk, .rst_n,
		.clock_ratio_select(sel), .endian_strap, .halt_req, .doze_req,
		.wake, .irq_n, .nmi_n, .ratio_q, .half_div_q, .core_mhz_q,
		.big_endian_q, .low_power_status, .irq_q, .nmi_q);
	board_model partner (.irq_val_n, .irq_drv, .nmi_drv, .irq_n, .nmi_n);
	initial begin
		forever #5 mclk = ~mclk;
	end
	task automatic step(int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic strap_test();
		for (int i = 0; i < 4; i++) begin
			rst_n = 1'h0;
			sel = i[1:0];
			endian_strap = i[0];
			step(2);
			`CHK("rst ratio", RATIO_RST, ratio_q)
			`CHK("rst div", HALF_DIV_1_2, half_div_q)
			`CHK("rst endian", ENDIAN_RST, big_endian_q)
			rst_n = 1'h1;
			step();
			`CHK("ratio", i[1:0], ratio_q)
			`CHK("div", div_tab[i], half_div_q)
			`CHK("mhz", 8'hc8, core_mhz_q)
			`CHK("endian", i[0], big_endian_q)
			sel = ~sel;
			endian_strap = ~endian_strap;
			step(2);
			`CHK("held ratio", i[1:0], ratio_q)
			`CHK("held div", div_tab[i], half_div_q)
			`CHK("held endian", i[0], big_endian_q)
		end
	endtask
	task automatic power_test();
		halt_req = 1'h1;
		doze_req = 1'h1;
		step();
		`CHK("halt", 1'h1, low_power_status)
		halt_req = 1'h0;
		doze_req = 1'h0;
		wake = 1'h1;
		step();
		`CHK("wake", 1'h0, low_power_status)
		wake = 1'h0;
		doze_req = 1'h1;
		step();
		doze_req = 1'h0;
		step();
		`CHK("doze", 1'h1, low_power_status)
		wake = 1'h1;
		step();
		`CHK("wake doze", 1'h0, low_power_status)
		wake = 1'h0;
		halt_req = 1'h1;
		step();
		halt_req = 1'h0;
		`CHK("halt again", 1'h1, low_power_status)
		rst_n = 1'h0;
		step();
		`CHK("rst status", 1'h0, low_power_status)
		rst_n = 1'h1;
		step();
		`CHK("run after rst", 1'h0, low_power_status)
	endtask
	task automatic irq_test();
		irq_drv = 1'h1;
		nmi_drv = 1'h1;
		irq_val_n = 4'ha;
		step();
		`CHK("irq", 4'h5, irq_q)
		`CHK("nmi", 1'h1, nmi_q)
		irq_val_n = 4'h3;
		step();
		`CHK("irq next", 4'hc, irq_q)
		irq_drv = 1'h0;
		nmi_drv = 1'h0;
		step();
		`CHK("irq idle", 4'h0, irq_q)
		`CHK("nmi idle", 1'h0, nmi_q)
	endtask
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		step(12);
		rst_n = 1'h1;
		step();
		strap_test();
		power_test();
		irq_test();
		print_verdict();
	end
	initial begin
		#5000;
		fail_count++;
		print_verdict();
	end
endmodule
